// ===== logic/cts_charge_timer.sv
// charge termination, top-off timer and safety timers of the charger control
//
// Functional notes
// R1 - terminate: above recharge, CV loop, low current
// R2 - done opens switch; supplement closes it
// R3 - termination reports 111 and pulses alert
// R4 - regulation loops suppress termination temporarily
// R5 - disable before termination only; latched afterwards
// R6 - enabling termination applies to current cycle
// R7 - top-off keeps CV charging until expiry
// R8 - top-off suspends and halves with safety timer
// R9 - top-off reports 110, expiry 111 plus alert
// R10 - top-off clears on enable, termination, restore
// R11 - top-off duration sampled at termination
// R12 - termination disabled means top-off never starts
// R13 - alert on top-off start/expiry; mask suppresses
// R14 - fast timer expiry sets flag, pulses alert
// R15 - trickle 1h, pre 2h/0.5h, fast 12h
// R16 - enable bits gate timers; enabling restarts
// R17 - stage entry starts its safety timer
// R18 - regulation halves timer rate unless disabled
// R19 - half rate persists until regulation ends
// R20 - faults, supplement suspend; restart resets timers
// R21 - fast timer resets on restart, stage, setting
// R22 - pre/trickle timers reset on restart, transitions
// R23 - phase codes 000..111 as listed
// R24 - charge needs bit high, pin low
// R25 - slow tick; half rate skips alternate ticks
`timescale 1ns/1ps
module cts_charge_timer
  import cts_pkg::*;
#(
  parameter int TickCycles = TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // loop and comparator indications from the analog side
  input wire cts_sense_t sense,
  // host configuration
  input wire cts_cfg_t cfg,
  // status and alert
  output cts_status_t status,
  output logic hostAlert
);
  typedef struct packed {
    cts_phase_t phase;
    logic prevEnable;
    logic [NUM_TMR-1:0] prevTimerEn;
    logic [1:0] prevFastSet;
    logic prevPreSet;
    logic [TICK_W-1:0] tickCount;
    logic halfPhase;
    logic halfRate;
    logic termLatched;
    logic [TMR_W-1:0] topoffTarget;
    logic [TMR_W-1:0] topoffCount;
    logic [NUM_TMR-1:0][TMR_W-1:0] safetyCount;
    logic fastFlag;
    logic timerFault;
    logic alert;
    logic battSwitch;
    logic charging;
  } cts_state_t;

  cts_state_t st;
  cts_state_t next_st;
  cts_sense_t sn;

  ////////////////////////////////////////////////////////////////////////////////
  // pin and comparator synchronisation

  cts_sync #(
    .W($bits(cts_sense_t))
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .din(sense),
    .dout(sn)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // per-timer enable, stage and limit

  logic [NUM_TMR-1:0] timerEn;
  logic [NUM_TMR-1:0] stageIs;
  logic [NUM_TMR-1:0] setChange;
  logic [NUM_TMR-1:0] timerOn;
  logic [NUM_TMR-1:0] timerClr;
  logic [NUM_TMR-1:0] timerExpired;
  logic [NUM_TMR-1:0][TMR_W-1:0] timerLimit;

  assign timerEn = {cfg.fastTimerEnable, cfg.prechargeTimerEnable, cfg.trickleTimerEnable}; // see R16
  // leaving a stage zeroes its timer, so entering it restarts it; CC and CV share the fast timer, so CC to CV keeps its count
  assign stageIs = {(st.phase == PH_CC) || (st.phase == PH_CV),
                    st.phase == PH_PRE,
                    st.phase == PH_TRICKLE}; // see R17
  assign setChange = {cfg.fastChargeTimerSetting != st.prevFastSet,
                      cfg.prechargeTimerSetting != st.prevPreSet,
                      1'b0}; // see R21
  assign timerLimit[TMR_TRICKLE] = TRICKLE_TICKS; // see R15
  assign timerLimit[TMR_PRE] = (cfg.prechargeTimerSetting == PRE_SET_2H) ? PRE_LONG_TICKS : PRE_SHORT_TICKS;
  assign timerLimit[TMR_FAST] = fastLimit(cfg.fastChargeTimerSetting);

  genvar g;
  generate
    for (g = 0; g < NUM_TMR; g++) begin : gTimer
      assign timerOn[g] = timerEn[g] && stageIs[g];
      // see R16, R21, R22
      assign timerClr[g] = !timerOn[g] || !st.prevTimerEn[g] || setChange[g];
      assign timerExpired[g] = timerOn[g] && (st.safetyCount[g] >= timerLimit[g]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  logic chargeEn;
  logic restart;
  logic regActive;
  logic tick;
  logic suspend;
  logic advance;
  logic termHit;
  logic fastExpire;
  logic chargingNext;
  cts_phase_t stage;

  always_comb begin
    next_st = st;
    chargeEn = cfg.chargeEnableBit && !sn.chargeEnablePin_n; // see R24
    restart = chargeEn && !st.prevEnable;
    regActive = sn.inputCurrentReg || sn.inputVoltageReg || sn.thermalReg;
    suspend = sn.chargeFault || sn.supplementMode; // see R20
    next_st.prevEnable = chargeEn;
    next_st.prevTimerEn = timerEn;
    next_st.prevFastSet = cfg.fastChargeTimerSetting;
    next_st.prevPreSet = cfg.prechargeTimerSetting;

    // slow tick from the system clock
    tick = st.tickCount == TICK_W'(TickCycles - 1); // see R25
    next_st.tickCount = tick ? '0 : st.tickCount + 1'b1;

    // disabling half rate mid-regulation is deferred until the loop lets go
    next_st.halfRate = regActive && (cfg.halfRateEnable || st.halfRate); // see R18, R19
    if (tick && !suspend && st.halfRate) begin
      next_st.halfPhase = !st.halfPhase;
    end
    // shared by safety and top-off counters so both stretch and stop together
    advance = tick && !suspend && (!st.halfRate || st.halfPhase); // see R8, R25

    // stage picked by battery voltage and loop
    if (!sn.aboveShortz) begin
      stage = PH_TRICKLE;
    end else if (!sn.aboveLowv) begin
      stage = PH_PRE;
    end else if (sn.cvLoop) begin
      stage = PH_CV;
    end else begin
      stage = PH_CC;
    end

    // latched state keeps termination alive once it happened
    termHit = ((st.phase == PH_CC) || (st.phase == PH_CV)) && sn.aboveRecharge && sn.cvLoop &&
              sn.belowTermCurrent && !regActive && (cfg.terminationEnable || st.termLatched); // see R1, R4, R5, R6, R12

    // safety counters
    for (int i = 0; i < NUM_TMR; i++) begin
      if (timerClr[i]) begin
        next_st.safetyCount[i] = '0;
      end else if (advance && (st.safetyCount[i] < timerLimit[i])) begin
        next_st.safetyCount[i] = st.safetyCount[i] + 1'b1;
      end
    end
    fastExpire = timerExpired[TMR_FAST]; // see R14

    if (!chargeEn) begin
      next_st.phase = PH_IDLE;
    end else if (restart) begin
      next_st.phase = stage;
      next_st.termLatched = 1'b0;
      next_st.timerFault = 1'b0;
      next_st.topoffCount = '0; // see R10
    end else begin
      case (st.phase)
        PH_TRICKLE, PH_PRE, PH_CC, PH_CV: begin
          if (|timerExpired) begin
            next_st.phase = PH_IDLE;
            next_st.timerFault = 1'b1;
          end else if (termHit) begin
            next_st.termLatched = 1'b1;
            next_st.topoffCount = '0; // see R10
            if (cfg.topoffDuration != TOPOFF_OFF) begin
              next_st.phase = PH_TOPOFF; // see R7, R9
              next_st.topoffTarget = topoffLimit(cfg.topoffDuration); // see R11
            end else begin
              next_st.phase = PH_DONE; // see R3
            end
          end else begin
            next_st.phase = stage;
          end
        end
        PH_TOPOFF: begin
          if (cfg.registerDefaultsRestore) begin
            next_st.topoffCount = '0; // see R10
            next_st.phase = PH_DONE;
          end else if (advance) begin
            next_st.topoffCount = st.topoffCount + 1'b1;
            if (st.topoffCount + 1'b1 >= st.topoffTarget) begin
              next_st.phase = PH_DONE; // see R9
            end
          end
        end
        PH_DONE: begin
          // recharge starts a fresh cycle, dropping the termination latch
          if (!sn.aboveRecharge) begin
            next_st.phase = stage;
            next_st.termLatched = 1'b0;
          end
        end
        PH_IDLE: begin
          next_st.phase = PH_IDLE;
        end
        default: begin
          next_st.phase = PH_IDLE;
        end
      endcase
    end

    // every phase change is a charge-cycle event
    next_st.alert = ((next_st.phase != st.phase) && !cfg.chargeEventMask) || fastExpire; // see R3, R9, R13, R14
    // set beats a simultaneous clear
    next_st.fastFlag = fastExpire || (st.fastFlag && !cfg.fastTimerFlagClear); // see R14

    chargingNext = (next_st.phase == PH_TRICKLE) || (next_st.phase == PH_PRE) || (next_st.phase == PH_CC) ||
                   (next_st.phase == PH_CV) || (next_st.phase == PH_TOPOFF);
    next_st.charging = chargingNext;
    next_st.battSwitch = chargingNext || sn.supplementMode; // see R2, R7
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs, all from state flops

  assign status.chargePhaseCode = st.phase; // see R23
  assign status.batterySwitch = st.battSwitch;
  assign status.charging = st.charging;
  assign status.fastTimerExpiredFlag = st.fastFlag;
  assign status.safetyTimerFault = st.timerFault;
  assign status.halfRateActive = st.halfRate;
  assign hostAlert = st.alert;
endmodule

// ===== logic/cts_pkg.sv
// constants and carrier types for the charge termination and safety timer block
package cts_pkg;
  // clock and slow tick
  localparam int CLK_HZ = 40000000;
  localparam int TICK_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_S;
  localparam int TICK_W = 26;
  localparam int TMR_W = 17;
  localparam int SYNC_STAGES = 3;

  // safety and top-off durations in their own units
  localparam int TRICKLE_HOURS = 1;
  localparam int PRE_LONG_HOURS = 2;
  localparam int PRE_SHORT_MIN = 30;
  localparam int FAST_5_HOURS = 5;
  localparam int FAST_8_HOURS = 8;
  localparam int FAST_12_HOURS = 12;
  localparam int FAST_24_HOURS = 24;
  localparam int TOPOFF_15_MIN = 15;
  localparam int TOPOFF_30_MIN = 30;
  localparam int TOPOFF_45_MIN = 45;

  // durations in slow ticks
  localparam logic [TMR_W-1:0] TRICKLE_TICKS = TMR_W'(TRICKLE_HOURS * 3600 / TICK_S);
  localparam logic [TMR_W-1:0] PRE_LONG_TICKS = TMR_W'(PRE_LONG_HOURS * 3600 / TICK_S);
  localparam logic [TMR_W-1:0] PRE_SHORT_TICKS = TMR_W'(PRE_SHORT_MIN * 60 / TICK_S);
  localparam logic [TMR_W-1:0] FAST_5_TICKS = TMR_W'(FAST_5_HOURS * 3600 / TICK_S);
  localparam logic [TMR_W-1:0] FAST_8_TICKS = TMR_W'(FAST_8_HOURS * 3600 / TICK_S);
  localparam logic [TMR_W-1:0] FAST_12_TICKS = TMR_W'(FAST_12_HOURS * 3600 / TICK_S);
  localparam logic [TMR_W-1:0] FAST_24_TICKS = TMR_W'(FAST_24_HOURS * 3600 / TICK_S);
  localparam logic [TMR_W-1:0] TOPOFF_15_TICKS = TMR_W'(TOPOFF_15_MIN * 60 / TICK_S);
  localparam logic [TMR_W-1:0] TOPOFF_30_TICKS = TMR_W'(TOPOFF_30_MIN * 60 / TICK_S);
  localparam logic [TMR_W-1:0] TOPOFF_45_TICKS = TMR_W'(TOPOFF_45_MIN * 60 / TICK_S);

  // setting codes
  localparam logic [1:0] FAST_SET_5H = 2'h0;
  localparam logic [1:0] FAST_SET_8H = 2'h1;
  localparam logic [1:0] FAST_SET_12H = 2'h2;
  localparam logic [1:0] FAST_SET_24H = 2'h3;
  localparam logic PRE_SET_2H = 1'h0;
  localparam logic [1:0] TOPOFF_OFF = 2'h0;
  localparam logic [1:0] TOPOFF_15M = 2'h1;
  localparam logic [1:0] TOPOFF_30M = 2'h2;

  // timer index
  localparam int TMR_TRICKLE = 0;
  localparam int TMR_PRE = 1;
  localparam int TMR_FAST = 2;
  localparam int NUM_TMR = 3;

  // charge phase, code equals the reported status
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_TRICKLE = 3'h1,
    PH_PRE = 3'h2,
    PH_CC = 3'h3,
    PH_CV = 3'h4,
    PH_TOPOFF = 3'h6,
    PH_DONE = 3'h7
  } cts_phase_t;

  // analog comparator and loop indications, asynchronous to clk
  typedef struct packed {
    logic inputCurrentReg;
    logic inputVoltageReg;
    logic thermalReg;
    logic cvLoop;
    logic aboveRecharge;
    logic belowTermCurrent;
    logic aboveShortz;
    logic aboveLowv;
    logic chargeFault;
    logic supplementMode;
    logic chargeEnablePin_n;
  } cts_sense_t;

  // host configuration bits, same clock
  typedef struct packed {
    logic chargeEnableBit;
    logic terminationEnable;
    logic [1:0] topoffDuration;
    logic chargeEventMask;
    logic [1:0] fastChargeTimerSetting;
    logic prechargeTimerSetting;
    logic trickleTimerEnable;
    logic prechargeTimerEnable;
    logic fastTimerEnable;
    logic halfRateEnable;
    logic registerDefaultsRestore;
    logic fastTimerFlagClear;
  } cts_cfg_t;

  // status toward the host and the power stage
  typedef struct packed {
    logic [2:0] chargePhaseCode;
    logic batterySwitch;
    logic charging;
    logic fastTimerExpiredFlag;
    logic safetyTimerFault;
    logic halfRateActive;
  } cts_status_t;

  function automatic logic [TMR_W-1:0] fastLimit(input logic [1:0] sel);
    case (sel)
      FAST_SET_5H: fastLimit = FAST_5_TICKS;
      FAST_SET_8H: fastLimit = FAST_8_TICKS;
      FAST_SET_12H: fastLimit = FAST_12_TICKS;
      default: fastLimit = FAST_24_TICKS;
    endcase
  endfunction

  function automatic logic [TMR_W-1:0] topoffLimit(input logic [1:0] sel);
    case (sel)
      TOPOFF_15M: topoffLimit = TOPOFF_15_TICKS;
      TOPOFF_30M: topoffLimit = TOPOFF_30_TICKS;
      default: topoffLimit = TOPOFF_45_TICKS;
    endcase
  endfunction
endpackage

// ===== logic/cts_sync.sv
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module cts_sync
  import cts_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // asynchronous input and filtered result
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } cts_sync_state_t;

  cts_sync_state_t st;
  cts_sync_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // per bit: only a settled level is passed on, one-cycle glitches die here
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.q;
endmodule

// ===== tb/cts_charge_timer_checker.sv
// port-level assertions for the charge timer
`timescale 1ns/1ps
module cts_charge_timer_checker
  import cts_pkg::*;
#(
  parameter int TickCycles = TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // inputs
  input wire cts_sense_t sense,
  input wire cts_cfg_t cfg,
  // outputs
  input wire cts_status_t status,
  input wire logic hostAlert
);
  logic [2:0] ph;
  logic blocked;
  logic [3:0] blockCnt;
  assign ph = status.chargePhaseCode;
  assign blocked = sense.inputCurrentReg | sense.inputVoltageReg | sense.thermalReg | !cfg.terminationEnable;
  // saturating count, long enough to cover the input synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blockCnt <= 4'h0;
    end else if (!blocked) begin
      blockCnt <= 4'h0;
    end else if (blockCnt != 4'hf) begin
      blockCnt <= blockCnt + 4'h1;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_NO_TERM_BLOCKED: assert property (
    blocked && blockCnt >= 4'h8 && (ph == 3'h3 || ph == 3'h4) |=> ph != 3'h6 && ph != 3'h7)
    else $error("termination while blocked");
  AST_ALERT_ON_CHANGE: assert property (
    $changed(ph) && !cfg.chargeEventMask && !$past(cfg.chargeEventMask) |-> hostAlert)
    else $error("phase change without alert");
  AST_MASKED_ALERT: assert property (
    hostAlert && cfg.chargeEventMask && $past(cfg.chargeEventMask) |-> status.fastTimerExpiredFlag)
    else $error("alert while masked");
  AST_ALERT_CAUSE: assert property (
    hostAlert |-> $changed(ph) || $rose(status.fastTimerExpiredFlag))
    else $error("alert without cause");
  AST_FLAG_ALERT: assert property (
    $rose(status.fastTimerExpiredFlag) |-> hostAlert)
    else $error("timer flag without alert");
  AST_FLAG_STICKY: assert property (
    status.fastTimerExpiredFlag && !cfg.fastTimerFlagClear && !cfg.registerDefaultsRestore
    |=> status.fastTimerExpiredFlag)
    else $error("timer flag lost");
  AST_NO_RESERVED: assert property (ph != 3'h5)
    else $error("reserved phase code");
  AST_ACTIVE_CHARGING: assert property (
    ph inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h6} |-> status.charging && status.batterySwitch)
    else $error("active phase without charging");
  AST_DONE_OPEN: assert property (
    (ph == 3'h7 && !sense.supplementMode)[*6] |-> !status.batterySwitch && !status.charging)
    else $error("switch closed after termination");
endmodule

// ===== tb/cts_analog_model.sv
// analog side model: loops and comparators seen by the charge timer
`timescale 1ns/1ps
module cts_analog_model
  import cts_pkg::*;
(
  // battery level 0 trickle 1 pre 2 fast 3 full
  input wire logic [1:0] level,
  // regulation loops, fault, supplement, pin
  input wire logic [2:0] regLoops,
  input wire logic fault,
  input wire logic supplement,
  input wire logic pinHigh,
  // comparator view
  output cts_sense_t sense
);
  always_comb begin
    sense.inputCurrentReg = regLoops[0];
    sense.inputVoltageReg = regLoops[1];
    sense.thermalReg = regLoops[2];
    sense.aboveShortz = level != 2'h0;
    sense.aboveLowv = level[1];
    // full battery meets all end conditions at once
    sense.cvLoop = level == 2'h3;
    sense.aboveRecharge = level == 2'h3;
    sense.belowTermCurrent = level == 2'h3;
    sense.chargeFault = fault;
    sense.supplementMode = supplement;
    sense.chargeEnablePin_n = pinHigh;
  end
endmodule

// ===== tb/charge_termination_safety_timer_tb_top.sv
// self-checking bench for the charge timer
`timescale 1ns/1ps
module charge_termination_safety_timer_tb_top;
  import cts_pkg::*;
  // short tick keeps the hour-long timers affordable
  localparam int TC = 2;
  localparam int TOL = 16;
  logic clk;
  logic rst;
  cts_cfg_t cfg;
  cts_sense_t sense;
  cts_status_t status;
  logic hostAlert;
  logic [1:0] level;
  logic [2:0] regLoops;
  logic supplement;
  logic fault;
  logic pinHigh;
  int miscompares;
  int comparisons;
  cts_analog_model model (.level(level), .regLoops(regLoops), .fault(fault), .supplement(supplement),
    .pinHigh(pinHigh), .sense(sense));
  cts_charge_timer #(.TickCycles(TC)) DUT (.clk(clk), .rst(rst), .sense(sense), .cfg(cfg),
    .status(status), .hostAlert(hostAlert));
  ////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic waitPhase(input logic [2:0] code, input int limit, output int n, output logic al);
    n = 0;
    while (status.chargePhaseCode !== code && n < limit) begin
      step(1);
      n++;
    end
    al = hostAlert;
    check("phase", status.chargePhaseCode, code);
  endtask
  task automatic restart(input logic [1:0] lv);
    level = lv;
    cfg.chargeEnableBit = 1'b0;
    step(8);
    cfg.chargeEnableBit = 1'b1;
  endtask
  task automatic near(input string name, input int n, input int exp);
    check(name, (n > exp - TOL) && (n < exp + TOL), 1'b1);
  endtask
  ////////////////////////////////////////
  task automatic testTerminate();
    int n;
    logic al;
    regLoops = 3'h1;
    restart(2'h2);
    waitPhase(3'h3, 20, n, al);
    check("start alert", al, 1'b1);
    level = 2'h3;
    step(40);
    check("held", status.chargePhaseCode == 3'h7, 1'b0);
    regLoops = 3'h0;
    waitPhase(3'h7, 20, n, al);
    check("done alert", al, 1'b1);
    check("switch open", status.batterySwitch, 1'b0);
    check("charging off", status.charging, 1'b0);
    supplement = 1'b1;
    step(8);
    check("switch closed", status.batterySwitch, 1'b1);
    supplement = 1'b0;
  endtask
  task automatic testTermEnable();
    int n;
    logic al;
    cfg.terminationEnable = 1'b0;
    restart(2'h3);
    step(40);
    check("no end", status.chargePhaseCode == 3'h7, 1'b0);
    cfg.terminationEnable = 1'b1;
    waitPhase(3'h7, 20, n, al);
    cfg.terminationEnable = 1'b0;
    step(20);
    check("latched", status.chargePhaseCode, 3'h7);
    cfg.terminationEnable = 1'b1;
  endtask
  task automatic testTopoff(input logic slow);
    int n;
    logic al;
    cfg.topoffDuration = TOPOFF_15M;
    cfg.chargeEventMask = slow;
    restart(2'h3);
    waitPhase(3'h6, 40, n, al);
    check("topoff alert", al, !slow);
    check("topoff switch", status.batterySwitch, 1'b1);
    // late write must not stretch this run
    cfg.topoffDuration = TOPOFF_30M;
    regLoops = {slow, 2'h0};
    waitPhase(3'h7, 9000, n, al);
    near("topoff span", n, int'(TOPOFF_15_TICKS) * TC * (slow ? 2 : 1));
    check("expiry alert", al, !slow);
    check("half rate", status.halfRateActive, slow);
    regLoops = 3'h0;
    cfg.topoffDuration = TOPOFF_OFF;
    cfg.chargeEventMask = 1'b0;
  endtask
  task automatic testPre();
    int n;
    logic al;
    cfg.prechargeTimerSetting = 1'b1;
    restart(2'h0);
    waitPhase(3'h1, 20, n, al);
    level = 2'h1;
    waitPhase(3'h2, 20, n, al);
    step(600);
    cfg.prechargeTimerEnable = 1'b0;
    step(4);
    cfg.prechargeTimerEnable = 1'b1;
    step(500);
    supplement = 1'b1;
    step(500);
    // fault takes over from supplement in the same step, so the hold is unbroken
    supplement = 1'b0;
    fault = 1'b1;
    step(500);
    fault = 1'b0;
    waitPhase(3'h0, 9000, n, al);
    near("pre span", n + 1500, int'(PRE_SHORT_TICKS) * TC + 1000);
    check("pre fault", status.safetyTimerFault, 1'b1);
  endtask
  task automatic testRestore();
    int n;
    logic al;
    cfg.topoffDuration = TOPOFF_30M;
    level = 2'h3;
    pinHigh = 1'b1;
    step(8);
    pinHigh = 1'b0;
    waitPhase(3'h6, 40, n, al);
    check("pin restart alert", al, 1'b1);
    step(20);
    cfg.registerDefaultsRestore = 1'b1;
    step(1);
    cfg.registerDefaultsRestore = 1'b0;
    check("restore phase", status.chargePhaseCode, 3'h7);
    check("restore alert", hostAlert, 1'b1);
    cfg.topoffDuration = TOPOFF_OFF;
  endtask
  task automatic testFast();
    int n;
    logic al;
    cfg.chargeEventMask = 1'b1;
    restart(2'h2);
    step(1000);
    cfg.fastChargeTimerSetting = FAST_SET_5H;
    waitPhase(3'h0, 40000, n, al);
    near("fast span", n, int'(FAST_5_TICKS) * TC);
    check("fast alert", al, 1'b1);
    check("fast flag", status.fastTimerExpiredFlag, 1'b1);
    cfg.fastTimerFlagClear = 1'b1;
    step(1);
    cfg.fastTimerFlagClear = 1'b0;
    step(1);
    check("flag cleared", status.fastTimerExpiredFlag, 1'b0);
  endtask
  ////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (70000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    miscompares = 0;
    comparisons = 0;
    rst = 1'b1;
    level = 2'h2;
    regLoops = 3'h0;
    supplement = 1'b0;
    fault = 1'b0;
    pinHigh = 1'b0;
    cfg = '0;
    cfg.terminationEnable = 1'b1;
    cfg.fastChargeTimerSetting = FAST_SET_12H;
    cfg.trickleTimerEnable = 1'b1;
    cfg.prechargeTimerEnable = 1'b1;
    cfg.fastTimerEnable = 1'b1;
    cfg.halfRateEnable = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    step(8);
    check("idle", status.chargePhaseCode, 3'h0);
    testTerminate();
    testTermEnable();
    testTopoff(1'b0);
    testTopoff(1'b1);
    testRestore();
    testPre();
    testFast();
    tally_and_finish();
  end
endmodule
bind cts_charge_timer cts_charge_timer_checker #(.TickCycles(TickCycles)) chk (.clk(clk), .rst(rst),
  .sense(sense), .cfg(cfg), .status(status), .hostAlert(hostAlert));
